// File: link_model.sv
// Link controller model: makes the link clock, drives and samples the shared bus
module link_model (
	output logic            lclk,  // Link clock
	input  wire logic       dir,   // Direction from transceiver
	input  wire logic       nxt,   // Throttle from transceiver
	input  wire logic [7:0] bus,   // Resolved data bus
	output logic      [7:0] ldata, // Byte driven while direction low
	output logic            stp    // Stop
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       dir_q = 1'b1;
	logic [8:0] rxq[$];
	initial begin
		lclk = 1'b0;
		ldata = 8'h00;
		stp = 1'b0;
		#7;
		forever #100 lclk = ~lclk;
	end
	// Bytes seen while the transceiver owns the bus, turn cycles skipped
	always @(posedge lclk) begin
		if (dir && dir_q)
			rxq.push_back({nxt, bus});
		dir_q <= dir;
	end
	task automatic send(input logic [7:0] b[$], input logic s);
		do @(posedge lclk); while (dir || dir_q);
		#1;
		foreach (b[i]) begin
			ldata <= b[i];
			do @(posedge lclk); while (!nxt);
			#1;
		end
		ldata <= 8'h00;
		if (s) begin
			stp <= 1'b1;
			@(posedge lclk);
			#1;
			stp <= 1'b0;
		end
	endtask : send
	task automatic read(input logic [7:0] b[$], output logic [7:0] v);
		logic [8:0] e;
		send(b, 1'b0);
		rxq.delete();
		while (rxq.size() == 0)
			@(posedge lclk);
		#1;
		e = rxq.pop_front();
		v = e[7:0];
	endtask : read
	task automatic wake;
		@(posedge lclk);
		#1;
		stp <= 1'b1;
		while (dir)
			@(posedge lclk);
		#1;
		stp <= 1'b0;
	endtask : wake
endmodule : link_model

// File: pin_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,   // System clock
	input  wire logic             reset, // Synchronous reset
	input  wire logic [WIDTH-1:0] d,     // Asynchronous inputs
	output logic      [WIDTH-1:0] q      // Synchronised outputs
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t r;
	sync_t r_nxt;

	always_comb begin
		r_nxt    = r;
		r_nxt.s1 = d;
		r_nxt.s2 = r.s1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign q = r.s2;

endmodule : pin_sync

// File: ulpi_bus_pkg.sv
// Shared constants and types for the transceiver-side link bus interface
package ulpi_bus_pkg;

	// Link command byte layout
	localparam int          CMD_HI          = 7;
	localparam int          CMD_LO          = 6;
	localparam logic [1:0]  CMD_IDLE        = 2'h0;
	localparam logic [1:0]  CMD_TX          = 2'h1;
	localparam logic [1:0]  CMD_REGW        = 2'h2;
	localparam logic [1:0]  CMD_REGR        = 2'h3;
	localparam logic [5:0]  EXT_ADDR        = 6'h2f;
	localparam logic [7:0]  IDLE_BYTE       = 8'h00;

	// Register array layout
	localparam int          REG_NUM_DEF     = 8;
	localparam int          REG_FUNC        = 0;
	localparam int          REG_OTG         = 1;
	localparam int          XCVR_LO         = 0;
	localparam int          TERM_BIT        = 2;
	localparam int          OPMODE_LO       = 3;
	localparam int          SUSPENDM_BIT    = 6;
	localparam int          DP_PD_BIT       = 1;
	localparam int          DM_PD_BIT       = 2;
	localparam logic [7:0]  FUNC_RESET      = 8'h41;
	localparam logic [7:0]  OTG_RESET       = 8'h06;
	localparam logic [7:0]  REG_RESET       = 8'h00;

	// Status byte sent to the link
	localparam int          STATUS_W        = 7;

	// Timing: system clock and link clock divider
	localparam int          SYS_CLK_NS      = 25;
	localparam int          LINK_PERIOD_NS  = 200;
	localparam int          DIV_HALF_DEF    = LINK_PERIOD_NS / (2 * SYS_CLK_NS);
	localparam int          DIV_W           = 8;

	// Receive end delay budget in high-speed clocks
	localparam int          RX_END_DELAY    = 43;
	localparam int          RX_END_DELAY_MAX = 63;

	typedef enum logic [3:0] {
		PH_STARTUP   = 4'h0,
		PH_TURN_DOWN = 4'h1,
		PH_IDLE      = 4'h2,
		PH_TX        = 4'h3,
		PH_TX_END    = 4'h4,
		PH_REGW_ADDR = 4'h5,
		PH_REGW_DATA = 4'h6,
		PH_REGW_STOP = 4'h7,
		PH_REGR_ADDR = 4'h8,
		PH_TURN_UP   = 4'h9,
		PH_SEND_LAST = 4'ha,
		PH_RX_STREAM = 4'hb,
		PH_LOWPWR    = 4'hc
	} phase_t;

	typedef enum logic [1:0] {
		PUR_REG = 2'h0,
		PUR_CMD = 2'h1,
		PUR_RX  = 2'h2
	} purpose_t;

endpackage : ulpi_bus_pkg

// File: ulpi_phy_bus.sv
// Transceiver-side synchronous link bus interface: arbitration, command decode, register array
// Function
// - Sample and launch every bus signal only at rising link clock edges. In low power the code sees stop and drives the pins without edges.
// - Link clock comes from the transceiver divider or from the link.
// - Transceiver drives data while direction is high, link while low.
// - A non-zero byte starts a transfer; all-zero means idle bus. The code decodes only the top two bits, so any 00xxxxxx byte is idle.
// - Raise direction to send; lower it and watch for commands otherwise.
// - Hold direction high while unable to accept data, e.g. PLL start-up.
// - Byte before the stop cycle is the packet's final byte.
// - Throttle high means byte accepted; link shows next byte next cycle.
// - Stop input also triggers start-up and resume from low power.
// - One undriven turn-around cycle per direction change; bus ignored then. The code drives the pins with no turn cycle on low power entry.
// - Synchronous mode plus low power mode with stopped clock, remapped pins.
// - Transceiver, termination, mode and pull-down controls live in registers.
// - Route each link command to transmitter or register array by type.
// - Receive end delay stays within 43 of allowed 63 clocks.
// - Twelve signals: clock, eight data, direction, throttle, stop.
// - Command top bits: 00 idle, 01 transmit, 10 write, 11 read.
module ulpi_phy_bus #(
	parameter int REG_NUM  = ulpi_bus_pkg::REG_NUM_DEF,
	parameter int DIV_HALF = ulpi_bus_pkg::DIV_HALF_DEF
) (
	input  wire logic                            clk,          // System clock, 40 MHz
	input  wire logic                            reset,        // Synchronous reset, active high
	input  wire logic                            clk_src_phy,  // Strap: transceiver makes link clock
	input  wire logic                            ulpi_clk_in,  // Link clock pin level
	output logic                                 ulpi_clk_out, // Link clock driven out
	output logic                                 ulpi_clk_oe,  // Link clock output enable
	input  wire logic [7:0]                      data_in,      // Data pins level
	output logic      [7:0]                      data_out,     // Data pins driven value
	output logic                                 data_oe,      // Data pins output enable
	output logic                                 dir,          // Bus direction
	output logic                                 nxt,          // Throttle
	input  wire logic                            stp,          // Stop from link
	input  wire logic                            pll_ready,    // Internal clocks stable
	input  wire logic [ulpi_bus_pkg::STATUS_W-1:0] status,     // Line, bus voltage, event, id status
	output logic      [7:0]                      tx_data,      // Byte to USB transmitter
	output logic                                 tx_last,      // Final byte of packet
	output logic                                 tx_valid,     // Transmit byte present
	input  wire logic                            tx_ready,     // Transmitter takes byte
	input  wire logic [7:0]                      rx_data,      // Received USB byte
	input  wire logic                            rx_last,      // Final received byte
	input  wire logic                            rx_valid,     // Received byte present
	output logic                                 rx_ready,     // Received byte taken, pulse
	output logic      [1:0]                      xcvr_select,  // Transceiver select
	output logic                                 term_select,  // Termination select
	output logic      [1:0]                      op_mode,      // Operating mode
	output logic                                 dp_pulldown,  // DP pull-down enable
	output logic                                 dm_pulldown,  // DM pull-down enable
	output logic                                 low_power     // Low power mode active
);

	localparam int SYNC_W = 11;

	typedef struct packed {
		ulpi_bus_pkg::phase_t              ph;
		ulpi_bus_pkg::purpose_t            pur;
		logic                              dir;
		logic                              nxt;
		logic [7:0]                        dout;
		logic                              doe;
		logic                              ext;
		logic [7:0]                        addr;
		logic [7:0]                        wdata;
		logic [8:0]                        pend;
		logic                              pend_v;
		logic [8:0]                        outw;
		logic                              out_v;
		logic [ulpi_bus_pkg::STATUS_W-1:0] sent_stat;
		logic                              rx_ready;
		logic                              clk_q;
		logic [7:0]                        din_q;
		logic                              stp_q;
		logic [ulpi_bus_pkg::DIV_W-1:0]    div;
		logic                              clk_o;
		logic                              src_phy;
		logic [1:0]                        strap_cnt;
		logic                              cmd_hold;
		logic                              low_power;
		logic [REG_NUM-1:0][7:0]           regs;
	} phy_t;

	phy_t r;
	phy_t r_nxt;

	logic [SYNC_W-1:0] sync_q;
	logic              s_clk;
	logic              s_stp;
	logic              s_src;
	logic [7:0]        s_data;
	logic              buf_in_ready;

	function automatic logic is_ext(input logic [7:0] b);
		is_ext = (b[5:0] == ulpi_bus_pkg::EXT_ADDR);
	endfunction : is_ext

	function automatic logic [1:0] cmd_of(input logic [7:0] b);
		cmd_of = b[ulpi_bus_pkg::CMD_HI:ulpi_bus_pkg::CMD_LO];
	endfunction : cmd_of

	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({ulpi_clk_in, stp, clk_src_phy, data_in}),
		.q     (sync_q)
	);

	assign s_clk  = sync_q[10];
	assign s_stp  = sync_q[9];
	assign s_src  = sync_q[8];
	assign s_data = sync_q[7:0];

	word_buf2 #(
		.WIDTH (9)
	) u_txbuf (
		.clk       (clk),
		.reset     (reset),
		.in_data   (r.outw),
		.in_valid  (r.out_v),
		.in_ready  (buf_in_ready),
		.out_data  ({tx_last, tx_data}),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	always_comb begin
		logic       tick;
		logic [7:0] b;
		logic       s;
		logic [7:0] rxcmd;
		tick  = 1'b0;
		b     = 8'h00;
		s     = 1'b0;
		rxcmd = 8'h00;
		r_nxt = r;
		// Rising edge seen on synced clock; pre-edge data kept one cycle back
		tick           = s_clk && !r.clk_q;
		b              = r.din_q;
		s              = r.stp_q;
		rxcmd          = {1'b0, status};
		r_nxt.clk_q    = s_clk;
		r_nxt.din_q    = s_data;
		r_nxt.stp_q    = s_stp;
		r_nxt.rx_ready = 1'b0;

		// Clock source strap followed until the synchroniser has filled
		if (r.strap_cnt != 2'h3) begin
			r_nxt.src_phy   = s_src;
			r_nxt.strap_cnt = r.strap_cnt + 2'h1;
		end
		// Divider runs only when this end makes the clock and not in low power
		if (r.src_phy && r.ph != ulpi_bus_pkg::PH_LOWPWR) begin
			if (r.div == ulpi_bus_pkg::DIV_W'(DIV_HALF - 1)) begin
				r_nxt.div   = '0;
				r_nxt.clk_o = !r.clk_o;
			end else begin
				r_nxt.div = r.div + ulpi_bus_pkg::DIV_W'(1);
			end
		end else begin
			r_nxt.div   = '0;
			r_nxt.clk_o = 1'b0;
		end

		// Staged transmit word enters the buffer when there is room
		if (r.out_v && buf_in_ready) begin
			r_nxt.out_v = 1'b0;
		end
		// Command byte stays on the bus until the first throttled edge takes it
		if (tick && r.nxt) begin
			r_nxt.cmd_hold = 1'b0;
		end

		case (r.ph)
			ulpi_bus_pkg::PH_STARTUP: begin
				r_nxt.dir = 1'b1;
				r_nxt.doe = 1'b0;
				if (tick && pll_ready) begin
					r_nxt.dir = 1'b0;
					r_nxt.ph  = ulpi_bus_pkg::PH_TURN_DOWN;
				end
			end
			ulpi_bus_pkg::PH_TURN_DOWN: begin
				if (tick) begin
					r_nxt.ph = ulpi_bus_pkg::PH_IDLE;
				end
			end
			ulpi_bus_pkg::PH_IDLE: begin
				if (tick) begin
					if (rx_valid) begin
						r_nxt.dir = 1'b1;
						r_nxt.pur = ulpi_bus_pkg::PUR_RX;
						r_nxt.ph  = ulpi_bus_pkg::PH_TURN_UP;
					end else if (status != r.sent_stat) begin
						r_nxt.dir = 1'b1;
						r_nxt.pur = ulpi_bus_pkg::PUR_CMD;
						r_nxt.ph  = ulpi_bus_pkg::PH_TURN_UP;
					end else begin
						r_nxt.cmd_hold = 1'b1;
						case (cmd_of(b))
							ulpi_bus_pkg::CMD_TX: begin
								r_nxt.pend   = {1'b0, b};
								r_nxt.pend_v = 1'b1;
								r_nxt.nxt    = 1'b1;
								r_nxt.ph     = ulpi_bus_pkg::PH_TX;
							end
							ulpi_bus_pkg::CMD_REGW: begin
								r_nxt.addr = {2'b00, b[5:0]};
								r_nxt.ext  = is_ext(b);
								r_nxt.nxt  = 1'b1;
								r_nxt.ph   = is_ext(b) ? ulpi_bus_pkg::PH_REGW_ADDR : ulpi_bus_pkg::PH_REGW_DATA;
							end
							ulpi_bus_pkg::CMD_REGR: begin
								r_nxt.addr = {2'b00, b[5:0]};
								r_nxt.ext  = is_ext(b);
								r_nxt.nxt  = 1'b1;
								r_nxt.ph   = ulpi_bus_pkg::PH_REGR_ADDR;
							end
							default: begin
								r_nxt.ph = ulpi_bus_pkg::PH_IDLE;
							end
						endcase
					end
				end
			end
			ulpi_bus_pkg::PH_TX: begin
				if (tick) begin
					if (s) begin
						// Byte held from before the stop is the final one
						r_nxt.nxt = 1'b0;
						if (!r_nxt.out_v) begin
							r_nxt.outw   = {1'b1, r.pend[7:0]};
							r_nxt.out_v  = 1'b1;
							r_nxt.pend_v = 1'b0;
							r_nxt.ph     = ulpi_bus_pkg::PH_IDLE;
						end else begin
							r_nxt.ph = ulpi_bus_pkg::PH_TX_END;
						end
					end else begin
						if (r.nxt && !r.cmd_hold) begin
							r_nxt.outw  = r.pend;
							r_nxt.out_v = r.pend_v;
							r_nxt.pend  = {1'b0, b};
						end
						// Throttle falls when the staging word cannot drain
						r_nxt.nxt = !r_nxt.out_v || buf_in_ready;
					end
				end
			end
			ulpi_bus_pkg::PH_TX_END: begin
				if (!r_nxt.out_v) begin
					r_nxt.outw   = {1'b1, r.pend[7:0]};
					r_nxt.out_v  = 1'b1;
					r_nxt.pend_v = 1'b0;
					r_nxt.ph     = ulpi_bus_pkg::PH_IDLE;
				end
			end
			ulpi_bus_pkg::PH_REGW_ADDR: begin
				if (tick && r.nxt && !r.cmd_hold) begin
					r_nxt.addr = b;
					r_nxt.ph   = ulpi_bus_pkg::PH_REGW_DATA;
				end
			end
			ulpi_bus_pkg::PH_REGW_DATA: begin
				if (tick && r.nxt && !r.cmd_hold) begin
					r_nxt.wdata = b;
					r_nxt.nxt   = 1'b0;
					r_nxt.ph    = ulpi_bus_pkg::PH_REGW_STOP;
				end
			end
			ulpi_bus_pkg::PH_REGW_STOP: begin
				if (tick && s) begin
					r_nxt.ph = ulpi_bus_pkg::PH_IDLE;
					if (r.addr < 8'(REG_NUM)) begin
						r_nxt.regs[r.addr[$clog2(REG_NUM)-1:0]] = r.wdata;
					end
					// Clearing suspend enters low power with direction high
					if (r.addr == 8'(ulpi_bus_pkg::REG_FUNC) && !r.wdata[ulpi_bus_pkg::SUSPENDM_BIT]) begin
						r_nxt.dir = 1'b1;
						r_nxt.ph  = ulpi_bus_pkg::PH_LOWPWR;
					end
				end
			end
			ulpi_bus_pkg::PH_REGR_ADDR: begin
				// Immediate read turns on the command edge, extended one edge later
				if (tick && r.nxt && (r.cmd_hold != r.ext)) begin
					if (r.ext) begin
						r_nxt.addr = b;
					end
					r_nxt.nxt = 1'b0;
					r_nxt.dir = 1'b1;
					r_nxt.pur = ulpi_bus_pkg::PUR_REG;
					r_nxt.ph  = ulpi_bus_pkg::PH_TURN_UP;
				end
			end
			ulpi_bus_pkg::PH_TURN_UP, ulpi_bus_pkg::PH_RX_STREAM: begin
				// Turn-around cycle in PH_TURN_UP: nothing driven, bus not read; PH_RX_STREAM keeps driving
				if (tick) begin
					r_nxt.doe = 1'b1;
					case (r.pur)
						ulpi_bus_pkg::PUR_REG: begin
							r_nxt.dout = (r.addr < 8'(REG_NUM)) ? r.regs[r.addr[$clog2(REG_NUM)-1:0]] : 8'h00;
							r_nxt.ph   = ulpi_bus_pkg::PH_SEND_LAST;
						end
						ulpi_bus_pkg::PUR_CMD: begin
							r_nxt.dout      = rxcmd;
							r_nxt.sent_stat = status;
							r_nxt.ph        = ulpi_bus_pkg::PH_SEND_LAST;
						end
						default: begin
							// Received bytes pass straight through to keep end delay low
							if (rx_valid) begin
								r_nxt.dout     = rx_data;
								r_nxt.nxt      = 1'b1;
								r_nxt.rx_ready = 1'b1;
								r_nxt.ph       = rx_last ? ulpi_bus_pkg::PH_SEND_LAST : ulpi_bus_pkg::PH_RX_STREAM;
							end else begin
								r_nxt.dout      = rxcmd;
								r_nxt.nxt       = 1'b0;
								r_nxt.sent_stat = status;
								r_nxt.ph        = ulpi_bus_pkg::PH_RX_STREAM;
							end
						end
					endcase
				end
			end
			ulpi_bus_pkg::PH_SEND_LAST: begin
				if (tick) begin
					r_nxt.dir  = 1'b0;
					r_nxt.nxt  = 1'b0;
					r_nxt.doe  = 1'b0;
					r_nxt.dout = ulpi_bus_pkg::IDLE_BYTE;
					r_nxt.ph   = ulpi_bus_pkg::PH_TURN_DOWN;
				end
			end
			ulpi_bus_pkg::PH_LOWPWR: begin
				// Clock stopped; pins carry line state; stop level seen without edges
				r_nxt.low_power = 1'b1;
				r_nxt.dir       = 1'b1;
				r_nxt.doe       = 1'b1;
				r_nxt.dout      = {6'h00, status[1:0]};
				if (s_stp) begin
					r_nxt.low_power = 1'b0;
					r_nxt.doe       = 1'b0;
					r_nxt.dout      = ulpi_bus_pkg::IDLE_BYTE;
					r_nxt.regs[ulpi_bus_pkg::REG_FUNC][ulpi_bus_pkg::SUSPENDM_BIT] = 1'b1;
					r_nxt.ph        = ulpi_bus_pkg::PH_STARTUP;
				end
			end
			default: begin
				r_nxt.ph = ulpi_bus_pkg::PH_STARTUP;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r                              <= '0;
			r.dir                          <= 1'b1;
			r.regs[ulpi_bus_pkg::REG_FUNC] <= ulpi_bus_pkg::FUNC_RESET;
			r.regs[ulpi_bus_pkg::REG_OTG]  <= ulpi_bus_pkg::OTG_RESET;
		end else begin
			r <= r_nxt;
		end
	end

	assign ulpi_clk_out = r.clk_o;
	assign ulpi_clk_oe  = r.src_phy;
	assign data_out     = r.dout;
	assign data_oe      = r.doe;
	assign dir          = r.dir;
	assign nxt          = r.nxt;
	assign rx_ready     = r.rx_ready;
	assign xcvr_select  = r.regs[ulpi_bus_pkg::REG_FUNC][ulpi_bus_pkg::XCVR_LO +: 2];
	assign term_select  = r.regs[ulpi_bus_pkg::REG_FUNC][ulpi_bus_pkg::TERM_BIT];
	assign op_mode      = r.regs[ulpi_bus_pkg::REG_FUNC][ulpi_bus_pkg::OPMODE_LO +: 2];
	assign dp_pulldown  = r.regs[ulpi_bus_pkg::REG_OTG][ulpi_bus_pkg::DP_PD_BIT];
	assign dm_pulldown  = r.regs[ulpi_bus_pkg::REG_OTG][ulpi_bus_pkg::DM_PD_BIT];
	assign low_power    = r.low_power;

endmodule : ulpi_phy_bus

// File: ulpi_phy_bus_assertions.sv
// Concurrent checks on the transceiver-side link bus ports
module ulpi_phy_bus_assertions (
	input wire logic       clk,       // System clock
	input wire logic       reset,     // Synchronous reset
	input wire logic       pll_ready, // Clocks stable
	input wire logic       dir,       // Direction
	input wire logic       nxt,       // Throttle
	input wire logic       data_oe,   // Data drive enable
	input wire logic [7:0] tx_data,   // Transmit byte
	input wire logic       tx_last,   // Final transmit byte
	input wire logic       tx_valid,  // Transmit byte present
	input wire logic       tx_ready,  // Transmitter takes byte
	input wire logic       rx_valid,  // Receive byte present
	input wire logic       rx_ready,  // Receive byte taken
	input wire logic       low_power  // Low power active
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence tx_stalled;
		tx_valid && !tx_ready;
	endsequence
	sequence tx_held;
		tx_valid && $stable(tx_data) && $stable(tx_last);
	endsequence
	sequence dir_taken;
		$rose(dir) && !low_power;
	endsequence
	AST_RESET_DIR: assert property (disable iff (1'b0) reset |=> dir)
		else $error("direction low after reset");
	AST_PLL_HOLD: assert property (!pll_ready |-> dir)
		else $error("direction low before clocks stable");
	AST_OE_DIR: assert property (data_oe |-> dir)
		else $error("bus driven while direction low");
	AST_TURN_UP: assert property (disable iff (reset || low_power) dir_taken |-> !data_oe[*4])
		else $error("bus driven in turn cycle");
	AST_TURN_DOWN: assert property ($fell(dir) |-> !data_oe)
		else $error("bus still driven at direction drop");
	AST_DIR_STANDS: assert property ($changed(dir) |=> $stable(dir)[*6])
		else $error("direction changed within link cycle");
	AST_NXT_STANDS: assert property ($rose(nxt) |=> nxt[*6])
		else $error("throttle shorter than link cycle");
	AST_RX_PULSE: assert property (rx_ready |-> rx_valid ##1 !rx_ready)
		else $error("receive take not a single pulse");
	AST_TX_HOLD: assert property (tx_stalled |=> tx_held)
		else $error("transmit byte lost under stall");
	AST_LOWPWR_DIR: assert property (low_power |-> dir)
		else $error("direction low in low power");
endmodule : ulpi_phy_bus_assertions

// File: ulpi_phy_bus_tb_top.sv
// Self-checking bench for the transceiver-side link bus interface
module ulpi_phy_bus_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       pll_ready = 1'b0;
	logic       tx_ready = 1'b1;
	logic       rx_last = 1'b0;
	logic       rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic [6:0] status = 7'h00;
	logic [7:0] last_bus = 8'h00;
	logic       lclk, stp, dir, nxt, data_oe, tx_last, tx_valid, rx_ready;
	logic       low_power, term_select, dp_pulldown, dm_pulldown, clk_out, clk_oe;
	logic [7:0] data_in, data_out, ldata, tx_data;
	logic [1:0] xcvr_select, op_mode;
	logic [8:0] txq[$];
	int         fail_count = 0;
	int         comparisons = 0;
	int         cyc = 0;

	always #12.5 clk = ~clk;
	// Released bus shows a changing pattern, never a held value
	assign data_in = data_oe ? data_out : ((dir || i_link_model.dir_q) ? ~last_bus : ldata);

	ulpi_phy_bus i_ulpi_phy_bus (
		.clk(clk), .reset(reset), .clk_src_phy(1'b0), .ulpi_clk_in(lclk),
		.ulpi_clk_out(clk_out), .ulpi_clk_oe(clk_oe),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp),
		.pll_ready(pll_ready), .status(status), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.xcvr_select(xcvr_select), .term_select(term_select), .op_mode(op_mode),
		.dp_pulldown(dp_pulldown), .dm_pulldown(dm_pulldown), .low_power(low_power)
	);
	link_model i_link_model (.lclk(lclk), .dir(dir), .nxt(nxt), .bus(data_in), .ldata(ldata), .stp(stp));

	always @(posedge clk) begin
		last_bus <= data_in;
		cyc <= cyc + 1;
		if (tx_valid && tx_ready)
			txq.push_back({tx_last, tx_data});
		if (cyc == 30000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic t_startup;
		repeat (8) @(negedge clk);
		check(dir, 1'b1, "dir in reset");
		check({xcvr_select, term_select, op_mode, dp_pulldown, dm_pulldown}, 9'h023, "config reset");
		reset = 1'b0;
		repeat (60) @(negedge clk);
		check(dir, 1'b1, "dir before pll");
		pll_ready = 1'b1;
		while (dir)
			@(negedge clk);
		repeat (400) @(negedge clk);
		check(dir, 1'b0, "dir idle");
		check({clk_oe, clk_out}, 9'h000, "link clock not driven");
	endtask : t_startup

	task automatic t_regs;
		logic [7:0] v;
		i_link_model.read('{8'hc1}, v);
		check(v, 8'h06, "otg reset read");
		i_link_model.send('{8'h80, 8'h5a}, 1'b1);
		i_link_model.send('{8'haf, 8'h01, 8'h18}, 1'b1);
		repeat (8) @(negedge clk);
		check({xcvr_select, term_select, op_mode}, 9'h013, "func fields");
		check({dp_pulldown, dm_pulldown}, 9'h000, "pulldowns");
		i_link_model.read('{8'hef, 8'h00}, v);
		check(v, 8'h5a, "ext read");
		i_link_model.read('{8'hc1}, v);
		check(v, 8'h18, "otg read");
		i_link_model.read('{8'hff}, v);
		check(v, 8'h00, "unmapped read");
	endtask : t_regs

	task automatic t_tx;
		logic [8:0] exp[3] = '{9'h011, 9'h022, 9'h133};
		txq.delete();
		@(negedge clk);
		tx_ready = 1'b0;
		fork
			i_link_model.send('{8'h43, 8'h11, 8'h22, 8'h33}, 1'b1);
			begin
				repeat (160) @(negedge clk);
				tx_ready = 1'b1;
			end
		join
		repeat (16) @(negedge clk);
		for (int i = 0; i < 3; i++)
			check(txq[txq.size() - 3 + i], exp[i], "tx byte");
	endtask : t_tx

	task automatic t_rx;
		logic [7:0] rb[2] = '{8'ha1, 8'ha2};
		int n = 0;
		@(negedge clk);
		status = 7'h15;
		while (i_link_model.rxq.size() == 0)
			@(negedge clk);
		check(i_link_model.rxq[0], 9'h015, "status byte");
		i_link_model.rxq.delete();
		foreach (rb[i]) begin
			@(negedge clk);
			rx_data = rb[i];
			rx_last = i[0];
			rx_valid = 1'b1;
			do @(posedge clk); while (!rx_ready);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		repeat (16) @(negedge clk);
		while (dir)
			@(negedge clk);
		foreach (i_link_model.rxq[i])
			if (i_link_model.rxq[i][8]) begin
				check(i_link_model.rxq[i][7:0], n ? 8'ha2 : 8'ha1, "rx byte");
				n++;
			end
		check(n, 2, "rx count");
	endtask : t_rx

	task automatic t_lowpower;
		logic [7:0] v;
		i_link_model.send('{8'h80, 8'h1a}, 1'b1);
		repeat (16) @(negedge clk);
		check({low_power, dir}, 9'h003, "low power entry");
		i_link_model.wake();
		repeat (400) @(negedge clk);
		check(low_power, 1'b0, "low power exit");
		i_link_model.read('{8'hc0}, v);
		check(v, 8'h5a, "resume restores func");
	endtask : t_lowpower

	initial begin
		t_startup();
		t_regs();
		t_tx();
		t_rx();
		t_lowpower();
		finish_test();
	end
endmodule : ulpi_phy_bus_tb_top

bind ulpi_phy_bus ulpi_phy_bus_assertions i_ulpi_phy_bus_assertions (
	.clk(clk), .reset(reset), .pll_ready(pll_ready), .dir(dir), .nxt(nxt), .data_oe(data_oe),
	.tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .low_power(low_power)
);

// File: word_buf2.sv
// Two-entry valid/ready buffer with registered outputs
module word_buf2 #(
	parameter int WIDTH = 9
) (
	input  wire logic             clk,       // System clock
	input  wire logic             reset,     // Synchronous reset
	input  wire logic [WIDTH-1:0] in_data,   // Word from the filling side
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	output logic      [WIDTH-1:0] out_data,  // Word to the draining side
	output logic                  out_valid, // Word present
	input  wire logic             out_ready  // Draining side takes word
);

	typedef struct packed {
		logic [WIDTH-1:0] head;
		logic             head_v;
		logic [WIDTH-1:0] spare;
		logic             spare_v;
	} buf_t;

	buf_t r;
	buf_t r_nxt;

	always_comb begin
		r_nxt = r;
		if (r.head_v && out_ready) begin
			if (r.spare_v) begin
				r_nxt.head    = r.spare;
				r_nxt.spare_v = 1'b0;
			end else begin
				r_nxt.head_v = 1'b0;
			end
		end
		// Push only while the spare slot is free
		if (in_valid && !r.spare_v) begin
			if (!r_nxt.head_v) begin
				r_nxt.head   = in_data;
				r_nxt.head_v = 1'b1;
			end else begin
				r_nxt.spare   = in_data;
				r_nxt.spare_v = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign in_ready  = !r.spare_v;
	assign out_data  = r.head;
	assign out_valid = r.head_v;

endmodule : word_buf2
